// file: src/ajd_core.sv
// alu and jump datapath: executes one instruction per request with its cycle count
// How it works
// RULE1: two-register add, with or without carry, sets Z C N V H in one cycle.
// RULE2: word plus immediate on a pair sets Z C N V S in two cycles.
// RULE3: subtract register or constant from destination, Z C N V H, one cycle.
// RULE4: subtract with carry, register or constant, Z C N V H, one cycle.
// RULE5: word minus immediate on a pair sets Z C N V S in two cycles.
// RULE6: and with register or constant, sets only Z N V, one cycle.
// RULE7: or with register or constant, xor registers, Z N V, one cycle.
// RULE8: set mask bits is or with constant, Z N V, one cycle.
// RULE9: clear mask bits ands with 0xFF minus constant, Z N V, one cycle.
// RULE10: check is and with itself, zeroing is xor with itself, Z N V.
// RULE11: three multiplies put 16-bit product in pair one:zero, Z C, two cycles.
// RULE12: fractional multiplies shift product left one first, Z C, two cycles.
// RULE13: pointer jump loads pc from z pointer, no flags, two cycles.
// RULE14: extended pointer jump loads pc from extension byte over z, two cycles.
// RULE15: invert, negate, plus one, minus one, all ones, one cycle; all ones keeps flags.
// RULE16: relative jump pc plus offset plus one, two cycles; direct jump loads target.
`timescale 1ns/1ps
`default_nettype none

module ajd_core
  import ajd_pkg::*;
(
  input  wire logic       clk_i,        // core clock, 100 MHz
  input  wire logic       rst_i,        // async reset, active high
  input  wire logic       req_valid_i,  // instruction presented
  input  wire ajd_req_t   req_i,        // instruction and operands
  output var  logic       busy_o,       // multi-cycle instruction in flight
  output var  logic       done_o,       // one-cycle pulse, result valid
  output var  ajd_rsp_t   rsp_o,        // write-back and pc load
  output var  ajd_flags_t flags_o       // status flags
);

  typedef enum logic {st_idle, st_wait} ajd_state_t;

  ajd_state_t state_ff, nxt_state;
  logic [1:0] cnt_ff, nxt_cnt;
  logic       busy_ff, nxt_busy;
  logic       done_ff, nxt_done;
  ajd_rsp_t   rsp_ff, nxt_rsp, hold_rsp_ff, nxt_hold_rsp;
  ajd_flags_t flags_ff, nxt_flags, hold_flags_ff, nxt_hold_flags;

  // result of an 8-bit add or subtract: {carry, half, overflow, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin, input logic sub);
    logic [7:0] bb;
    logic       ci;
    logic [8:0] s;
    logic [4:0] lo;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    // subtraction runs as add of complement, so carries turn into borrows
    add8 = {s[8] ^ sub, lo[4] ^ sub, (a[7] == bb[7]) && (s[7] != a[7]), s[7:0]};
  endfunction : add8

  // 16-bit product with per-operand signedness
  // one extra sign bit per operand lets a single multiplier serve all three modes
  function automatic logic [15:0] mul8(input logic [7:0] a, input logic [7:0] b,
                                       input logic sa, input logic sb);
    logic signed [17:0] p;
    p    = $signed({sa & a[7], a}) * $signed({sb & b[7], b});
    mul8 = p[15:0];
  endfunction : mul8

  // compute result, flags and cycle count of one instruction
  // combinational from req_i and flags_ff, so operands need only stand on the take edge
  ajd_rsp_t   ex_rsp;
  ajd_flags_t ex_flags;
  logic [1:0] ex_cyc;

  always_comb begin
    logic [10:0] a8;
    logic [16:0] w17;
    logic [15:0] prod;
    logic        is_sub;
    logic        is_frac;
    logic [7:0]  lres;
    a8       = '0;
    w17      = '0;
    prod     = WORD_ZERO;
    is_sub   = 1'b0;
    is_frac  = 1'b0;
    lres     = BYTE_ZERO;
    ex_rsp   = RSP_RST;
    ex_flags = flags_ff;
    ex_cyc   = CYC_ONE;
    ex_rsp.pc = req_i.pc;
    case (req_i.op)
      op_add, op_add_carry, op_sub, op_minus_constant,
      op_minus_with_carry, op_minus_constant_with_carry,
      op_twos_invert_plus_one: begin
        is_sub = (req_i.op != op_add) && (req_i.op != op_add_carry);
        case (req_i.op)
          op_add:                       a8 = add8(req_i.rd, req_i.rr, 1'b0, 1'b0);        // RULE1
          op_add_carry:                 a8 = add8(req_i.rd, req_i.rr, flags_ff.c, 1'b0);  // RULE1
          op_sub:                       a8 = add8(req_i.rd, req_i.rr, 1'b0, 1'b1);        // RULE3
          op_minus_constant:            a8 = add8(req_i.rd, req_i.k, 1'b0, 1'b1);         // RULE3
          op_minus_with_carry:          a8 = add8(req_i.rd, req_i.rr, flags_ff.c, 1'b1);  // RULE4
          op_minus_constant_with_carry: a8 = add8(req_i.rd, req_i.k, flags_ff.c, 1'b1);   // RULE4
          default:                      a8 = add8(BYTE_ZERO, req_i.rd, 1'b0, 1'b1);       // RULE15
        endcase
        ex_rsp.data    = {8'h00, a8[7:0]};
        ex_rsp.wr_byte = 1'b1;
        ex_flags.c     = a8[10];
        ex_flags.h     = a8[9];
        ex_flags.v     = a8[8];
        ex_flags.n     = a8[7];
        ex_flags.z     = (a8[7:0] == BYTE_ZERO);
      end
      op_word_plus_immediate, op_word_minus_immediate: begin
        is_sub = (req_i.op == op_word_minus_immediate);
        // only the low six constant bits reach the pair; higher bits are ignored
        if (is_sub) begin
          w17 = {1'b0, req_i.pair} - {11'h000, req_i.k[WORD_IMM_W-1:0]};                 // RULE5
          ex_flags.v = req_i.pair[15] & ~w17[15];
          ex_flags.c = w17[15] & ~req_i.pair[15];
        end else begin
          w17 = {1'b0, req_i.pair} + {11'h000, req_i.k[WORD_IMM_W-1:0]};                 // RULE2
          ex_flags.v = ~req_i.pair[15] & w17[15];
          ex_flags.c = ~w17[15] & req_i.pair[15];
        end
        ex_rsp.data    = w17[15:0];
        ex_rsp.wr_pair = 1'b1;
        ex_flags.n     = w17[15];
        ex_flags.z     = (w17[15:0] == WORD_ZERO);
        ex_flags.s     = w17[15] ^ ex_flags.v;
        ex_cyc         = CYC_TWO;                                                         // RULE2
      end
      op_and, op_conjunction_constant, op_or, op_disjunction_constant, op_xor_registers,
      op_set_mask_bits, op_clear_mask_bits, op_zero_sign_check, op_zero_register: begin
        case (req_i.op)
          op_and:                  lres = req_i.rd & req_i.rr;                // RULE6
          op_conjunction_constant: lres = req_i.rd & req_i.k;                 // RULE6
          op_or:                   lres = req_i.rd | req_i.rr;                // RULE7
          op_disjunction_constant: lres = req_i.rd | req_i.k;                 // RULE7
          op_xor_registers:        lres = req_i.rd ^ req_i.rr;                // RULE7
          op_set_mask_bits:        lres = req_i.rd | req_i.k;                 // RULE8
          op_clear_mask_bits:      lres = req_i.rd & (BYTE_ONES - req_i.k);   // RULE9
          op_zero_sign_check:      lres = req_i.rd & req_i.rd;                // RULE10
          default:                 lres = req_i.rd ^ req_i.rd;                // RULE10
        endcase
        // check only sets flags, so the destination is left alone
        ex_rsp.data    = {8'h00, lres};
        ex_rsp.wr_byte = (req_i.op != op_zero_sign_check);
        ex_flags.v     = 1'b0;                                                // RULE6
        ex_flags.n     = lres[7];
        ex_flags.z     = (lres == BYTE_ZERO);
      end
      op_bitwise_invert: begin
        lres           = BYTE_ONES - req_i.rd;                                // RULE15
        ex_rsp.data    = {8'h00, lres};
        ex_rsp.wr_byte = 1'b1;
        ex_flags.c     = 1'b1;
        ex_flags.v     = 1'b0;
        ex_flags.n     = lres[7];
        ex_flags.z     = (lres == BYTE_ZERO);
      end
      op_plus_one, op_minus_one: begin
        a8 = add8(req_i.rd, BYTE_ONE, 1'b0, req_i.op == op_minus_one);        // RULE15
        // carry and half carry are not touched by step operations
        ex_rsp.data    = {8'h00, a8[7:0]};
        ex_rsp.wr_byte = 1'b1;
        ex_flags.v     = a8[8];
        ex_flags.n     = a8[7];
        ex_flags.z     = (a8[7:0] == BYTE_ZERO);
      end
      op_all_ones_register: begin
        // no flag is named for this op, so ex_flags keeps flags_ff
        ex_rsp.data    = {8'h00, BYTE_ONES};                                  // RULE15
        ex_rsp.wr_byte = 1'b1;
      end
      op_product_unsigned, op_product_signed, op_product_signed_by_unsigned,
      op_fractional_product_unsigned, op_fractional_product_signed,
      op_fractional_product_mixed: begin
        is_frac = (req_i.op == op_fractional_product_unsigned) ||
                  (req_i.op == op_fractional_product_signed) ||
                  (req_i.op == op_fractional_product_mixed);
        case (req_i.op)
          op_product_signed, op_fractional_product_signed:
            prod = mul8(req_i.rd, req_i.rr, 1'b1, 1'b1);                      // RULE11
          op_product_signed_by_unsigned, op_fractional_product_mixed:
            prod = mul8(req_i.rd, req_i.rr, 1'b1, 1'b0);                      // RULE11
          default:
            prod = mul8(req_i.rd, req_i.rr, 1'b0, 1'b0);                      // RULE11
        endcase
        // carry takes the top product bit before the fractional shift drops it
        ex_flags.c     = prod[15];
        ex_rsp.data    = is_frac ? {prod[14:0], 1'b0} : prod;                 // RULE12
        ex_rsp.wr_prod = 1'b1;
        ex_flags.z     = (ex_rsp.data == WORD_ZERO);
        ex_cyc         = CYC_TWO;                                             // RULE11
      end
      op_relative_jump: begin
        // offset is sign-extended to the full pc width, so backward jumps wrap
        ex_rsp.pc = req_i.pc + {{(PC_W-REL_W){req_i.rel[REL_W-1]}}, req_i.rel}
                    + {{(PC_W-1){1'b0}}, 1'b1};                               // RULE16
        ex_rsp.pc_load = 1'b1;
        ex_cyc         = CYC_TWO;                                             // RULE16
      end
      op_pointer_jump: begin
        ex_rsp.pc      = {6'h00, req_i.zptr};                                 // RULE13
        ex_rsp.pc_load = 1'b1;
        ex_cyc         = CYC_TWO;                                             // RULE13
      end
      op_extended_pointer_jump: begin
        // extension bits above the pc width are dropped, only the low six count
        ex_rsp.pc      = {req_i.jump_extension_byte[PC_W-17:0], req_i.zptr};  // RULE14
        ex_rsp.pc_load = 1'b1;
        ex_cyc         = CYC_TWO;                                             // RULE14
      end
      op_direct_jump: begin
        // the only three-cycle op; the two-bit counter would not cover a fourth
        ex_rsp.pc      = req_i.target;                                        // RULE16
        ex_rsp.pc_load = 1'b1;
        ex_cyc         = CYC_THREE;
      end
      default: begin
        ex_rsp = RSP_RST;
      end
    endcase
  end

  // sequencing: results and flags commit together when the count expires
  always_comb begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_busy       = busy_ff;
    nxt_done       = 1'b0;
    nxt_rsp        = rsp_ff;
    nxt_flags      = flags_ff;
    nxt_hold_rsp   = hold_rsp_ff;
    nxt_hold_flags = hold_flags_ff;
    case (state_ff)
      st_idle: begin
        // one-cycle ops commit at once; longer ones park their result until done
        if (req_valid_i) begin
          if (ex_cyc == CYC_ONE) begin
            nxt_rsp   = ex_rsp;
            nxt_flags = ex_flags;
            nxt_done  = 1'b1;
          end else begin
            nxt_hold_rsp   = ex_rsp;
            nxt_hold_flags = ex_flags;
            nxt_cnt        = ex_cyc - CYC_TWO;
            nxt_busy       = 1'b1;
            nxt_state      = st_wait;
          end
        end
      end
      st_wait: begin
        // requests are ignored here; flags used by them would be stale
        if (cnt_ff == 2'h0) begin
          nxt_rsp   = hold_rsp_ff;
          nxt_flags = hold_flags_ff;
          nxt_done  = 1'b1;
          nxt_busy  = 1'b0;
          nxt_state = st_idle;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      default: begin
        nxt_state = st_idle;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // flags clear too, so carry variants start from a zero carry
      state_ff      <= st_idle;
      cnt_ff        <= 2'h0;
      busy_ff       <= 1'b0;
      done_ff       <= 1'b0;
      rsp_ff        <= RSP_RST;
      flags_ff      <= FLAGS_RST;
      hold_rsp_ff   <= RSP_RST;
      hold_flags_ff <= FLAGS_RST;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      busy_ff       <= nxt_busy;
      done_ff       <= nxt_done;
      rsp_ff        <= nxt_rsp;
      flags_ff      <= nxt_flags;
      hold_rsp_ff   <= nxt_hold_rsp;
      hold_flags_ff <= nxt_hold_flags;
    end
  end

  assign busy_o  = busy_ff;
  assign done_o  = done_ff;
  assign rsp_o   = rsp_ff;
  assign flags_o = flags_ff;

endmodule : ajd_core

`default_nettype wire

// file: pkg/ajd_pkg.sv
// package: opcodes, carriers and constants of the alu and jump datapath
package ajd_pkg;

  localparam int unsigned PC_W        = 22;
  localparam int unsigned REL_W       = 12;
  localparam int unsigned WORD_IMM_W  = 6;

  // cycle counts per instruction class
  localparam logic [1:0] CYC_ONE      = 2'h1;
  localparam logic [1:0] CYC_TWO      = 2'h2;
  localparam logic [1:0] CYC_THREE    = 2'h3;

  localparam logic [7:0]  BYTE_ONES   = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [PC_W-1:0] PC_RST  = 22'h00_0000;

  // flag bit positions within the packed flag word
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;

  typedef enum logic [5:0] {
    op_add, op_add_carry, op_word_plus_immediate,
    op_sub, op_minus_constant, op_minus_with_carry, op_minus_constant_with_carry,
    op_word_minus_immediate,
    op_and, op_conjunction_constant, op_or, op_disjunction_constant, op_xor_registers,
    op_set_mask_bits, op_clear_mask_bits, op_zero_sign_check, op_zero_register,
    op_bitwise_invert, op_twos_invert_plus_one, op_plus_one, op_minus_one,
    op_all_ones_register,
    op_product_unsigned, op_product_signed, op_product_signed_by_unsigned,
    op_fractional_product_unsigned, op_fractional_product_signed,
    op_fractional_product_mixed,
    op_relative_jump, op_pointer_jump, op_extended_pointer_jump, op_direct_jump
  } ajd_op_t;

  typedef struct packed {
    ajd_op_t              op;
    logic [7:0]           rd;          // destination register value
    logic [7:0]           rr;          // source register value
    logic [7:0]           k;           // immediate constant
    logic [15:0]          pair;        // register pair, high:low
    logic [15:0]          zptr;        // z pointer pair
    logic [7:0]           jump_extension_byte;
    logic [PC_W-1:0]      pc;          // address of current instruction
    logic [REL_W-1:0]     rel;         // signed relative offset
    logic [PC_W-1:0]      target;      // absolute jump target
  } ajd_req_t;

  typedef struct packed {
    logic [15:0]          data;        // byte in [7:0], or pair / product
    logic                 wr_byte;     // write data[7:0] to destination
    logic                 wr_pair;     // write data to destination pair
    logic                 wr_prod;     // write data to pair one:zero
    logic                 pc_load;     // load program counter
    logic [PC_W-1:0]      pc;
  } ajd_rsp_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } ajd_flags_t;

  localparam ajd_flags_t FLAGS_RST = '0;
  localparam ajd_rsp_t   RSP_RST   = '0;

endpackage : ajd_pkg

// file: bench/ajd_core_props.sv
// checker: result and timing assertions on the datapath ports
`timescale 1ns/1ps
`default_nettype none

module ajd_core_props
  import ajd_pkg::*;
(
  input wire logic       clk_i,        // core clock
  input wire logic       rst_i,        // async reset
  input wire logic       req_valid_i,  // request strobe
  input wire ajd_req_t   req_i,        // request
  input wire logic       busy_o,       // in flight
  input wire logic       done_o,       // result pulse
  input wire ajd_rsp_t   rsp_o,        // write-back
  input wire ajd_flags_t flags_o       // status flags
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // request history, so results can be tied to the operands taken
  ajd_req_t q1_ff;
  ajd_req_t q2_ff;
  ajd_req_t q3_ff;
  logic     take;
  assign take = req_valid_i && !busy_o;
  always_ff @(posedge clk_i) begin
    q1_ff <= req_i;
    q2_ff <= q1_ff;
    q3_ff <= q2_ff;
  end

  a_add_byte_result: assert property (take && req_i.op == op_add |=> done_o
    && rsp_o.wr_byte && rsp_o.data[7:0] == q1_ff.rd + q1_ff.rr) else $error("add wrong");
  a_sub_byte_result: assert property (take && req_i.op == op_sub |=> done_o
    && rsp_o.data[7:0] == q1_ff.rd - q1_ff.rr) else $error("subtract wrong");
  a_word_two_cycle: assert property (take && req_i.op == op_word_plus_immediate
    |=> busy_o && !done_o ##1 done_o && rsp_o.wr_pair
    && rsp_o.data == q2_ff.pair + q2_ff.k[5:0]) else $error("word add wrong");
  a_and_clears_v: assert property (take && req_i.op == op_and |=> done_o
    && !flags_o.v && rsp_o.data[7:0] == (q1_ff.rd & q1_ff.rr)) else $error("and wrong");
  a_product_pair: assert property (take && req_i.op == op_product_unsigned |-> ##2
    done_o && rsp_o.wr_prod && rsp_o.data == 16'(q2_ff.rd) * 16'(q2_ff.rr))
    else $error("product wrong");
  a_pointer_pc: assert property (take && req_i.op == op_pointer_jump |-> ##2 done_o
    && rsp_o.pc_load && rsp_o.pc == {6'h00, q2_ff.zptr} && $stable(flags_o))
    else $error("pointer jump wrong");
  a_ext_pointer_pc: assert property (take && req_i.op == op_extended_pointer_jump
    |-> ##2 done_o && rsp_o.pc == {q2_ff.jump_extension_byte[5:0], q2_ff.zptr})
    else $error("extended jump wrong");
  a_direct_three: assert property (take && req_i.op == op_direct_jump
    |=> busy_o[*2] ##1 done_o && rsp_o.pc == q3_ff.target) else $error("direct jump wrong");
  a_all_ones_keep: assert property (take && req_i.op == op_all_ones_register
    |=> done_o && rsp_o.data[7:0] == 8'hFF && $stable(flags_o)) else $error("all ones wrong");
endmodule : ajd_core_props

bind ajd_core ajd_core_props ajd_core_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o), .done_o(done_o),
  .rsp_o(rsp_o), .flags_o(flags_o));

`default_nettype wire

// file: bench/ajd_core_test.sv
// testbench: random sweep of every opcode against a behavioural model
`timescale 1ns/1ps
`default_nettype none

module ajd_core_test;
  import ajd_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        req_valid_i;
  ajd_req_t    req_i;
  logic        busy_o;
  logic        done_o;
  ajd_rsp_t    rsp_o;
  ajd_flags_t  flags_o;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] seed;
  ajd_flags_t  mf;
  ajd_flags_t  ef;
  logic [31:0] ev;
  logic [3:0]  ew;
  int          el;

  ajd_core ajd_core_i (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .rsp_o(rsp_o), .flags_o(flags_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic byte_res(input logic [7:0] r);
    ev = {24'h00_0000, r};
    ef.z = r == 8'h00;
    ef.n = r[7];
  endtask : byte_res

  task automatic lg(input logic [7:0] r);
    byte_res(r);
    ef.v = 1'b0;
  endtask : lg

  task automatic arith(input logic [7:0] a, input logic [7:0] b, input logic ci, input logic sub);
    logic [8:0] r;
    if (sub) begin
      r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      ef.h = {1'b0, a[3:0]} < {1'b0, b[3:0]} + {4'h0, ci};
      ef.v = (a[7] != b[7]) && (r[7] != a[7]);
    end else begin
      r = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      ef.h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F;
      ef.v = (a[7] == b[7]) && (r[7] != a[7]);
    end
    ef.c = r[8];
    byte_res(r[7:0]);
  endtask : arith

  task automatic direct_jump(input logic [21:0] t, input int n);
    ev = {10'h000, t};
    ew = 4'h1;
    el = n;
  endtask : direct_jump

  task automatic run(input ajd_op_t o);
    ajd_req_t    q;
    logic [127:0] bits;
    logic [15:0] p;
    logic [16:0] w;
    logic        sa;
    logic        sb;
    int          n;
    bits = {rnd(), rnd(), rnd(), rnd()};
    q = ajd_req_t'(bits[$bits(ajd_req_t)-1:0]);
    q.op = o;
    ef = mf;
    ew = 4'h8;
    el = 1;
    case (o)
      op_add:                       arith(q.rd, q.rr, 1'b0, 1'b0);
      op_add_carry:                 arith(q.rd, q.rr, mf.c, 1'b0);
      op_sub:                       arith(q.rd, q.rr, 1'b0, 1'b1);
      op_minus_constant:            arith(q.rd, q.k, 1'b0, 1'b1);
      op_minus_with_carry:          arith(q.rd, q.rr, mf.c, 1'b1);
      op_minus_constant_with_carry: arith(q.rd, q.k, mf.c, 1'b1);
      op_and:                       lg(q.rd & q.rr);
      op_conjunction_constant:      lg(q.rd & q.k);
      op_or:                        lg(q.rd | q.rr);
      op_disjunction_constant:      lg(q.rd | q.k);
      op_xor_registers:             lg(q.rd ^ q.rr);
      op_set_mask_bits:             lg(q.rd | q.k);
      op_clear_mask_bits:           lg(q.rd & (8'hFF - q.k));
      op_zero_register:             lg(q.rd ^ q.rd);
      op_twos_invert_plus_one:      arith(8'h00, q.rd, 1'b0, 1'b1);
      op_all_ones_register:         ev = 32'h0000_00FF;
      op_zero_sign_check: begin
        lg(q.rd & q.rd);
        ew = 4'h0;
      end
      op_bitwise_invert: begin
        lg(8'hFF - q.rd);
        ef.c = 1'b1;
      end
      op_plus_one, op_minus_one: begin
        lg(o == op_plus_one ? q.rd + 8'h01 : q.rd - 8'h01);
        ef.v = ev[7:0] == (o == op_plus_one ? 8'h80 : 8'h7F);
      end
      op_word_plus_immediate, op_word_minus_immediate: begin
        sa = o == op_word_plus_immediate;
        w = sa ? {1'b0, q.pair} + {11'h000, q.k[5:0]} : {1'b0, q.pair} - {11'h000, q.k[5:0]};
        ev = {16'h0000, w[15:0]};
        ef.z = w[15:0] == 16'h0000;
        ef.n = w[15];
        ef.c = w[16];
        ef.v = sa ? !q.pair[15] && w[15] : q.pair[15] && !w[15];
        ef.s = ef.n ^ ef.v;
        ew = 4'h4;
        el = 2;
      end
      op_relative_jump:         direct_jump(q.pc + {{10{q.rel[11]}}, q.rel} + 22'h00_0001, 2);
      op_pointer_jump:          direct_jump({6'h00, q.zptr}, 2);
      op_extended_pointer_jump: direct_jump({q.jump_extension_byte[5:0], q.zptr}, 2);
      op_direct_jump:           direct_jump(q.target, 3);
      default: begin
        sa = !(o inside {op_product_unsigned, op_fractional_product_unsigned});
        sb = o inside {op_product_signed, op_fractional_product_signed};
        // sign-extend first so one 16-bit multiply serves all three signedness modes
        p = {{8{sa & q.rd[7]}}, q.rd} * {{8{sb & q.rr[7]}}, q.rr};
        ef.c = p[15];
        if (o >= op_fractional_product_unsigned) p = p << 1;
        ev = {16'h0000, p};
        ef.z = p == 16'h0000;
        ew = 4'h2;
        el = 2;
      end
    endcase
    @(negedge clk_i);
    req_i = q;
    req_valid_i = 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      // keep a disturbing request up while busy; it must be ignored
      if (done_o !== 1'b1) req_i.op = op_zero_register;
    end while (done_o !== 1'b1 && n < 5);
    req_valid_i = 1'b0;
    check(n, el);
    check({rsp_o.wr_byte, rsp_o.wr_pair, rsp_o.wr_prod, rsp_o.pc_load}, ew);
    if (ew != 4'h0) check(ew[3] ? {24'h00_0000, rsp_o.data[7:0]} : ew[0] ? {10'h000, rsp_o.pc}
      : {16'h0000, rsp_o.data}, ev);
    check(flags_o, ef);
    mf = ef;
    @(negedge clk_i);
    check(done_o, 1'b0);
  endtask : run

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    seed = 32'h0000_0046;
    mf = FLAGS_RST;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    check({busy_o, done_o, flags_o, rsp_o.data}, 32'h0000_0000);
    for (int r = 0; r < 16; r++) begin
      for (int i = 0; i < 32; i++) run(ajd_op_t'(i));
      $display("round %0d ended, %0d checks", r, checks_done);
    end
    stop_test();
  end
endmodule : ajd_core_test

`default_nettype wire
